// ---- shared/txcfg_defines.vh ----
// constants for the tx pin, sync word and frame length configuration bank
`ifndef TXCFG_DEFINES_VH
`define TXCFG_DEFINES_VH

`define TXCFG_OFF_PIN1      6'h01
`define TXCFG_OFF_PIN0      6'h02
`define TXCFG_OFF_THR       6'h03
`define TXCFG_OFF_MARK_HI   6'h04
`define TXCFG_OFF_MARK_LO   6'h05
`define TXCFG_OFF_FLEN      6'h06

`define TXCFG_RST_PIN1      8'h2E
`define TXCFG_RST_PIN0      8'h3F
`define TXCFG_RST_THR       8'h07
`define TXCFG_RST_MARK_HI   8'hD3
`define TXCFG_RST_MARK_LO   8'h91
`define TXCFG_RST_FLEN      8'hFF

`define TXCFG_BIT_DRIVE     7
`define TXCFG_BIT_TEMP      7
`define TXCFG_BIT_INV       6
`define TXCFG_SEL_MSB       5
`define TXCFG_SEL_RST_PIN1  6'h2E
`define TXCFG_SEL_RST_PIN0  6'h3F
`define TXCFG_SEL_HIGH_Z    6'h2E

`define TXCFG_THR_BASE      7'h3D
`define TXCFG_LEN_FIXED     2'h0
`define TXCFG_LEN_VARIABLE  2'h1
`define TXCFG_LEN_INFINITE  2'h2

`endif

// ---- hw/txcfg_threshold.v ----
// tx queue threshold compare
`timescale 1ns/1ps
`default_nettype none
module txcfg_threshold (
  input  wire       sys_clk_i,
  input  wire       reset_i,
  input  wire [3:0] level_select_i,
  input  wire [6:0] queue_count_i,
  output reg        above_o
);
`include "txcfg_defines.vh"
  // byte count for setting n is 61 - 4n
  function [6:0] thr_bytes;
    input [3:0] n;
    begin
      thr_bytes = `TXCFG_THR_BASE - {1'b0, n, 2'b00};
    end
  endfunction

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      above_o <= 1'b0;
    end else begin
      above_o <= (queue_count_i >= thr_bytes(level_select_i));
    end
  end
endmodule // txcfg_threshold
`default_nettype wire

// ---- hw/txcfg_length.v ----
// frame length selection from length mode
`timescale 1ns/1ps
`default_nettype none
module txcfg_length (
  input  wire       sys_clk_i,
  input  wire       reset_i,
  input  wire [1:0] length_mode_i,
  input  wire [7:0] fixed_length_i,
  input  wire [7:0] first_byte_i,
  output reg  [7:0] frame_length_o,
  output reg        infinite_o
);
`include "txcfg_defines.vh"
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      frame_length_o <= `TXCFG_RST_FLEN;
      infinite_o     <= 1'b0;
    end else begin
      case (length_mode_i)
        `TXCFG_LEN_FIXED: begin
          frame_length_o <= fixed_length_i;
          infinite_o     <= 1'b0;
        end
        `TXCFG_LEN_VARIABLE: begin
          frame_length_o <= first_byte_i;
          infinite_o     <= 1'b0;
        end
        `TXCFG_LEN_INFINITE: begin
          frame_length_o <= fixed_length_i;
          infinite_o     <= 1'b1;
        end
        default: begin
          // reserved mode behaves as fixed
          frame_length_o <= fixed_length_i;
          infinite_o     <= 1'b0;
        end
      endcase
    end
  end
endmodule // txcfg_length
`default_nettype wire

// ---- hw/txcfg_regs.v ----
// configuration register bank: output pins, queue threshold, frame marker, length
`timescale 1ns/1ps
`default_nettype none
module txcfg_regs (
  input  wire       sys_clk_i,
  input  wire       reset_i,
  input  wire       soft_reset_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [5:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire [6:0] queue_count_i,
  input  wire [1:0] length_mode_i,
  input  wire [7:0] first_byte_i,
  input  wire       pin_zero_signal_i,
  input  wire       pin_one_signal_i,
  output reg  [7:0] reg_rdata_o,
  output reg        reg_hit_o,
  output reg  [5:0] out_pin_zero_select_o,
  output reg  [5:0] out_pin_one_select_o,
  output reg        out_pin_drive_strength_o,
  output reg        general_out_pin_zero_o,
  output reg        general_out_pin_one_o,
  output reg        general_out_pin_one_oe_o,
  output reg        temp_sensor_enable_o,
  output reg  [15:0] frame_marker_o,
  output wire       queue_above_o,
  output wire [7:0] frame_length_o,
  output wire       frame_infinite_o
);
`include "txcfg_defines.vh"

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [7:0] output_pin1_config;
  reg [7:0] output_pin0_config;
  reg [7:0] tx_queue_threshold;
  reg [7:0] frame_marker_high;
  reg [7:0] frame_marker_low;
  reg [7:0] fixed_frame_length;

  wire any_reset = reset_i | soft_reset_i;

  always @(posedge sys_clk_i) begin
    if (any_reset) begin
      output_pin1_config <= `TXCFG_RST_PIN1;
      output_pin0_config <= `TXCFG_RST_PIN0;
      tx_queue_threshold <= `TXCFG_RST_THR;
      frame_marker_high  <= `TXCFG_RST_MARK_HI;
      frame_marker_low   <= `TXCFG_RST_MARK_LO;
      fixed_frame_length <= `TXCFG_RST_FLEN;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `TXCFG_OFF_PIN1:    output_pin1_config <= reg_wdata_i;
        `TXCFG_OFF_PIN0:    output_pin0_config <= reg_wdata_i;
        `TXCFG_OFF_THR:     tx_queue_threshold <= reg_wdata_i;
        `TXCFG_OFF_MARK_HI: frame_marker_high  <= reg_wdata_i;
        `TXCFG_OFF_MARK_LO: frame_marker_low   <= reg_wdata_i;
        `TXCFG_OFF_FLEN:    fixed_frame_length <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  reg [7:0] next_rdata;
  reg       next_hit;

  always @* begin
    next_hit = 1'b1;
    case (reg_addr_i)
      `TXCFG_OFF_PIN1:    next_rdata = output_pin1_config;
      `TXCFG_OFF_PIN0:    next_rdata = output_pin0_config;
      `TXCFG_OFF_THR:     next_rdata = tx_queue_threshold;
      `TXCFG_OFF_MARK_HI: next_rdata = frame_marker_high;
      `TXCFG_OFF_MARK_LO: next_rdata = frame_marker_low;
      `TXCFG_OFF_FLEN:    next_rdata = fixed_frame_length;
      default: begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
      reg_hit_o   <= 1'b0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
      reg_hit_o   <= next_hit;
    end
  end

  // ----------------------------------------
  // output pin drive
  // ----------------------------------------
  // select 0x2E on pin 1 means high impedance
  localparam [5:0] SEL_HIGH_Z = `TXCFG_SEL_HIGH_Z;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      out_pin_zero_select_o    <= `TXCFG_SEL_RST_PIN0;
      out_pin_one_select_o     <= `TXCFG_SEL_RST_PIN1;
      out_pin_drive_strength_o <= 1'b0;
      general_out_pin_zero_o   <= 1'b0;
      general_out_pin_one_o    <= 1'b0;
      general_out_pin_one_oe_o <= 1'b0;
      temp_sensor_enable_o     <= 1'b0;
      frame_marker_o           <= {`TXCFG_RST_MARK_HI, `TXCFG_RST_MARK_LO};
    end else begin
      out_pin_zero_select_o    <= output_pin0_config[`TXCFG_SEL_MSB:0];
      out_pin_one_select_o     <= output_pin1_config[`TXCFG_SEL_MSB:0];
      out_pin_drive_strength_o <= output_pin1_config[`TXCFG_BIT_DRIVE];
      general_out_pin_zero_o   <= pin_zero_signal_i ^ output_pin0_config[`TXCFG_BIT_INV];
      general_out_pin_one_o    <= pin_one_signal_i ^ output_pin1_config[`TXCFG_BIT_INV];
      general_out_pin_one_oe_o <= (output_pin1_config[`TXCFG_SEL_MSB:0] != SEL_HIGH_Z);
      temp_sensor_enable_o     <= output_pin0_config[`TXCFG_BIT_TEMP];
      frame_marker_o           <= {frame_marker_high, frame_marker_low};
    end
  end

  // ----------------------------------------
  // threshold and length users
  // ----------------------------------------
  txcfg_threshold u_thr (
    .sys_clk_i      (sys_clk_i),
    .reset_i        (reset_i),
    .level_select_i (tx_queue_threshold[3:0]),
    .queue_count_i  (queue_count_i),
    .above_o        (queue_above_o)
  );

  txcfg_length u_len (
    .sys_clk_i      (sys_clk_i),
    .reset_i        (reset_i),
    .length_mode_i  (length_mode_i),
    .fixed_length_i (fixed_frame_length),
    .first_byte_i   (first_byte_i),
    .frame_length_o (frame_length_o),
    .infinite_o     (frame_infinite_o)
  );
endmodule // txcfg_regs
`default_nettype wire

// ---- tb/txcfg_host.sv ----
// host model driving register writes and reads
`timescale 1ns/1ps
`default_nettype none
module txcfg_host (
  input  wire logic       clk_i,
  output var  logic       wr_o,
  output var  logic       rd_o,
  output var  logic [5:0] addr_o,
  output var  logic [7:0] data_o
);
  // production test offset is arbitrary and lies outside this bank
  localparam logic [5:0] PROD_TEST_OFF = 6'h3C;
  initial {wr_o, rd_o, addr_o, data_o} = 16'h0000;
  task automatic put(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {wr_o, rd_o, addr_o} = {w, !w, a};
    data_o = (a == 6'h02 && d[7]) ? 8'h80 :
             (a == 6'h03) ? {4'h0, d[3:0]} : d;
    @(negedge clk_i);
    {wr_o, rd_o, addr_o, data_o} = {2'h0, ~a, ~data_o};
  endtask
  // production test setup before the temperature sensor is enabled
  task automatic prep_temp;
    put(1'b1, PROD_TEST_OFF, 8'hBF);
  endtask
endmodule // txcfg_host
`default_nettype wire

// ---- tb/txcfg_checker.sv ----
// port assertions for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module txcfg_checker (
  input wire logic        sys_clk_i, reset_i, soft_reset_i, reg_wr_i, reg_rd_i,
  input wire logic        reg_hit_o, general_out_pin_one_oe_o, queue_above_o, frame_infinite_o,
  input wire logic [5:0]  reg_addr_i, out_pin_one_select_o,
  input wire logic [7:0]  reg_wdata_i, reg_rdata_o, first_byte_i, frame_length_o,
  input wire logic [6:0]  queue_count_i,
  input wire logic [1:0]  length_mode_i,
  input wire logic [15:0] frame_marker_o
);
  logic [3:0] thr;
  logic       exp_above;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || soft_reset_i) thr <= 4'h7;
    else if (reg_wr_i && reg_addr_i == 6'h03) thr <= reg_wdata_i[3:0];
    exp_above <= !reset_i && queue_count_i >= 7'h3D - {1'b0, thr, 2'h0};
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  property p_miss; reg_rd_i && (reg_addr_i == 6'h00 || reg_addr_i > 6'h06)
    |=> !reg_hit_o && reg_rdata_o == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read answered");
  property p_mk; reg_wr_i && reg_addr_i == 6'h04 && !soft_reset_i ##1 !soft_reset_i
    |=> frame_marker_o[15:8] == $past(reg_wdata_i, 2); endproperty
  a_mk: assert property (p_mk) else $error("marker high byte");
  property p_oe; out_pin_one_select_o == 6'h2E |-> !general_out_pin_one_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("pin one not released");
  property p_srst; soft_reset_i |=> ##1 frame_marker_o == 16'hD391; endproperty
  a_srst: assert property (p_srst) else $error("soft reset marker");
  property p_thr; queue_above_o == exp_above; endproperty
  a_thr: assert property (p_thr) else $error("threshold flag");
  property p_var; length_mode_i == 2'h1 |=> frame_length_o == $past(first_byte_i); endproperty
  a_var: assert property (p_var) else $error("variable length");
  property p_inf; length_mode_i == 2'h2 |=> frame_infinite_o; endproperty
  a_inf: assert property (p_inf) else $error("infinite mode");
  property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  cover property (reg_rd_i && reg_addr_i == 6'h07);
  cover property (queue_above_o);
  cover property (soft_reset_i);
endmodule // txcfg_checker
bind txcfg_regs txcfg_checker u_chk (.*);
`default_nettype wire

// ---- tb/txcfg_regs_bench.sv ----
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module txcfg_regs_bench;
  logic clk = 0, rst = 1, srst = 0, ps1 = 0, wr, rd, rd_d = 0, hit, ds, p1, oe, temp, above, inf;
  logic ps0 = 0, p0;
  logic [5:0] ad, sel0, sel1;
  logic [7:0] wd, rdat, flen, fb = 0, x, rv [8];
  logic [7:0] rs [8] = '{8'h00, 8'h2E, 8'h3F, 8'h07, 8'hD3, 8'h91, 8'hFF, 8'h00};
  logic [6:0] qc = 0;
  logic [1:0] lm = 0;
  logic [15:0] mk;
  logic [8:0] q [$];
  int seed = 32'h0594, n_fail = 0, checked = 0;
  always #2 clk = ~clk;
  txcfg_host u_txcfg_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(ad), .data_o(wd));
  txcfg_regs u_txcfg_regs (.sys_clk_i(clk), .reset_i(rst), .soft_reset_i(srst),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(ad), .reg_wdata_i(wd), .queue_count_i(qc),
    .length_mode_i(lm), .first_byte_i(fb), .pin_zero_signal_i(ps0), .pin_one_signal_i(ps1),
    .reg_rdata_o(rdat), .reg_hit_o(hit), .out_pin_zero_select_o(sel0),
    .out_pin_one_select_o(sel1), .out_pin_drive_strength_o(ds), .general_out_pin_zero_o(p0),
    .general_out_pin_one_o(p1), .general_out_pin_one_oe_o(oe), .temp_sensor_enable_o(temp),
    .frame_marker_o(mk), .queue_above_o(above), .frame_length_o(flen),
    .frame_infinite_o(inf));
  task automatic chk(input string s, input logic [15:0] e, v);
    checked++;
    if (v !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", s, e, v);
    end
  endtask
  task rd_reg(input int a);
    q.push_back({a > 0 && a < 7, rv[a]});
    u_txcfg_host.put(0, a[5:0], 8'h00);
  endtask
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) if (rd_d) chk("rdata", q.pop_front(), {hit, rdat});
  task finish_test;
    for (int i = 0; i < 50 && q.size() > 0; i++) @(negedge clk);
    if (q.size() > 0) n_fail++;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000 n_fail++;
    finish_test();
  end
  initial begin
    rv = rs;
    repeat (6) @(negedge clk);
    rst = 0;
    for (int a = 0; a < 8; a++) rd_reg(a);
    $display("reset values done");
    for (int a = 1; a < 8; a++) begin
      x = $random(seed);
      if (a == 2) x[7] = 0;
      if (a == 3) x[7:4] = 0;
      if (a < 7) rv[a] = x;
      u_txcfg_host.put(1, a[5:0], x);
      rd_reg(a);
    end
    chk("marker", {rv[4], rv[5]}, mk);
    chk("fixed", rv[6], flen);
    $display("write readback done");
    for (int n = 0; n < 16; n++) begin
      u_txcfg_host.put(1, 6'h03, n[7:0]);
      qc = 7'd61 - 4 * n - ($random(seed) & 1);
      repeat (2) @(negedge clk);
      chk("above", qc >= 61 - 4 * n, above);
    end
    fb = $random(seed);
    lm = 1;
    repeat (2) @(negedge clk);
    chk("variable", fb, flen);
    lm = 2;
    repeat (2) @(negedge clk);
    chk("infinite", {1'b1, rv[6]}, {inf, flen});
    lm = 3;
    repeat (2) @(negedge clk);
    chk("reserved", {1'b0, rv[6]}, {inf, flen});
    $display("threshold and length done");
    ps1 = 1;
    ps0 = 1;
    u_txcfg_host.put(1, 6'h01, 8'hC5);
    u_txcfg_host.put(1, 6'h02, 8'h45);
    repeat (2) @(negedge clk);
    chk("pins inverted", 16'hA145, {ds, p1, oe, temp, sel1, sel0});
    chk("pin zero inverted", 0, p0);
    u_txcfg_host.prep_temp();
    u_txcfg_host.put(1, 6'h02, 8'hFF);
    repeat (2) @(negedge clk);
    chk("pins", 16'hB140, {ds, p1, oe, temp, sel1, sel0});
    chk("pin zero", 1, p0);
    $display("pins done");
    srst = 1;
    @(negedge clk);
    srst = 0;
    rv = rs;
    for (int a = 0; a < 8; a++) rd_reg(a);
    chk("oe", 0, oe);
    $display("soft reset done");
    finish_test();
  end
endmodule // txcfg_regs_bench
`default_nettype wire
